// [rtl/cdrf_map.svh]
`ifndef CDRF_MAP_SVH
`define CDRF_MAP_SVH
`define CDRF_STD_ARB_LAST 11
`define CDRF_EXT_ARB_LAST 31
`define CDRF_CTRL_LEN 6
`define CDRF_CRC_LEN 15
`define CDRF_CRC_POLY 15'h4599
`define CDRF_EOF_LEN 7
`define CDRF_STUFF_RUN 5
`define CDRF_FORBID_TOP 7'h7f
`define CDRF_IDE_POS 12
`define CDRF_STD_HDR_LAST 17
`define CDRF_EXT_HDR_LAST 37
`define CDRF_BIT_DIV 125
`define CDRF_DOMINANT 1'b0
`define CDRF_RECESSIVE 1'b1
`endif

// [rtl/cdrf_pkg.sv]
`include "cdrf_map.svh"
package cdrf_pkg;
  typedef enum logic [3:0] {
    TX_IDLE = 4'h0, TX_SOF = 4'h1, TX_ARB = 4'h3, TX_CTRL = 4'h2, TX_DATA = 4'h6,
    TX_CRC = 4'h7, TX_CDEL = 4'h5, TX_ASLOT = 4'h4, TX_ADEL = 4'hc, TX_EOF = 4'hd
  } cdrf_tx_state_t;
  typedef enum logic [3:0] {
    RX_IDLE = 4'h0, RX_HDR = 4'h1, RX_DATA = 4'h3, RX_CRC = 4'h2, RX_CDEL = 4'h6,
    RX_ASLOT = 4'h7, RX_ADEL = 4'h5, RX_EOF = 4'h4, RX_WAIT = 4'hc
  } cdrf_rx_state_t;
  typedef logic [6:0] cdrf_cnt_t;

  // One CRC-15 step per unstuffed bit
  function automatic logic [14:0] cdrf_crc_step(input logic [14:0] c, input logic b);
    cdrf_crc_step = {c[13:0], 1'b0} ^ ((c[14] ^ b) ? `CDRF_CRC_POLY : 15'h0);
  endfunction
endpackage

// [rtl/cdrf_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface cdrf_if;
  logic bit_tick;
  logic tx_level;
  logic ack_level;
  logic bus;
  // Wired-AND bus: any dominant driver wins
  assign bus = tx_level & ack_level;
  modport tx_end (output bit_tick, output tx_level, input bus);
  modport rx_end (input bit_tick, output ack_level, input bus);
endinterface
`default_nettype wire

// [rtl/cdrf_tx.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cdrf_map.svh"
module cdrf_tx
  import cdrf_pkg::*;
#(
  parameter int BIT_DIV = `CDRF_BIT_DIV
) (
  input wire logic clk,             // System clock
  input wire logic reset_n,         // Synchronous reset, active low
  cdrf_if.tx_end link,              // Shared bus
  input wire logic req,             // Send request pulse
  input wire logic req_ext,         // Extended format
  input wire logic req_rtr,         // Remote frame
  input wire logic [28:0] req_id,   // Identifier, base in [28:18]
  input wire logic [3:0] req_dlc,   // Data length code
  input wire logic [63:0] req_data, // First byte in [63:56]
  output logic busy,                // Frame pending or on bus
  output logic refused,             // Forbidden identifier pulse
  output logic done,                // Frame finished pulse
  output logic acked,               // Last frame was acknowledged
  output logic lost                 // Arbitration lost pulse
);
  localparam logic [15:0] DIV_LAST = 16'(BIT_DIV - 1);

  cdrf_tx_state_t state_q, next_state, adv_state;
  cdrf_cnt_t cnt_q, next_cnt, adv_cnt;
  cdrf_cnt_t arb_last_q, next_arb_last;
  cdrf_cnt_t nbits_q, next_nbits;
  logic [15:0] div_q, next_div;
  logic [31:0] arb_q, next_arb;
  logic [5:0] ctrl_q, next_ctrl;
  logic [63:0] data_q, next_data;
  logic [14:0] crc_q, next_crc;
  logic [2:0] run_q, next_run;
  logic last_q, next_last;
  logic stuff_q, next_stuff;
  logic level_q, next_level;
  logic pend_q, next_pend;
  logic refused_q, next_refused;
  logic done_q, next_done;
  logic acked_q, next_acked;
  logic lost_q, next_lost;
  logic tick, go, fbit, region;

  assign tick = (div_q == DIV_LAST);
  assign region = (state_q == TX_SOF) || (state_q == TX_ARB) || (state_q == TX_CTRL) ||
                  (state_q == TX_DATA) || (state_q == TX_CRC);

  always_comb begin
    next_div = tick ? 16'h0 : div_q + 16'h1;
    next_state = state_q;
    next_cnt = cnt_q;
    next_arb_last = arb_last_q;
    next_nbits = nbits_q;
    next_arb = arb_q;
    next_ctrl = ctrl_q;
    next_data = data_q;
    next_crc = crc_q;
    next_run = run_q;
    next_last = last_q;
    next_stuff = stuff_q;
    next_level = level_q;
    next_pend = pend_q;
    next_refused = 1'b0;
    next_done = 1'b0;
    next_acked = acked_q;
    next_lost = 1'b0;
    adv_state = state_q;
    adv_cnt = cnt_q;
    go = 1'b0;
    fbit = `CDRF_RECESSIVE;
    if (req && state_q == TX_IDLE && !pend_q) begin
      if (req_id[28:22] == `CDRF_FORBID_TOP) begin
        next_refused = 1'b1;
      end else begin
        next_pend = 1'b1;
        if (req_ext) begin
          next_arb = {req_id[28:18], `CDRF_RECESSIVE, `CDRF_RECESSIVE, req_id[17:0], req_rtr};
          next_arb_last = 7'(`CDRF_EXT_ARB_LAST);
        end else begin
          next_arb = {req_id[28:18], req_rtr, 20'h0};
          next_arb_last = 7'(`CDRF_STD_ARB_LAST);
        end
        next_ctrl = {`CDRF_DOMINANT, `CDRF_DOMINANT, req_dlc};
        next_data = req_data;
        if (req_rtr) begin
          next_nbits = 7'h0;
        end else if (req_dlc[3]) begin
          next_nbits = 7'h40;
        end else begin
          next_nbits = {1'b0, req_dlc[2:0], 3'h0};
        end
        next_acked = 1'b0;
      end
    end
    if (tick) begin
      if (state_q == TX_ARB && level_q && !stuff_q && !link.bus) begin
        next_state = TX_IDLE;
        next_level = `CDRF_RECESSIVE;
        next_last = `CDRF_RECESSIVE;
        next_run = 3'h0;
        next_lost = 1'b1;
      end else if (region && run_q == 3'(`CDRF_STUFF_RUN)) begin
        next_level = ~last_q;
        next_last = ~last_q;
        next_run = 3'h1;
        next_stuff = 1'b1;
      end else begin
        go = 1'b1;
        case (state_q)
          TX_IDLE: begin
            if (pend_q) begin
              adv_state = TX_SOF;
              adv_cnt = 7'h0;
              next_pend = 1'b0;
            end else begin
              go = 1'b0;
            end
          end
          TX_SOF: begin
            adv_state = TX_ARB;
            adv_cnt = 7'h0;
          end
          TX_ARB: begin
            if (cnt_q == arb_last_q) begin
              adv_state = TX_CTRL;
              adv_cnt = 7'h0;
            end else begin
              adv_cnt = cnt_q + 7'h1;
            end
          end
          TX_CTRL: begin
            if (cnt_q == 7'(`CDRF_CTRL_LEN - 1)) begin
              adv_state = (nbits_q == 7'h0) ? TX_CRC : TX_DATA;
              adv_cnt = 7'h0;
            end else begin
              adv_cnt = cnt_q + 7'h1;
            end
          end
          TX_DATA: begin
            if (cnt_q == nbits_q - 7'h1) begin
              adv_state = TX_CRC;
              adv_cnt = 7'h0;
            end else begin
              adv_cnt = cnt_q + 7'h1;
            end
          end
          TX_CRC: begin
            if (cnt_q == 7'(`CDRF_CRC_LEN - 1)) begin
              adv_state = TX_CDEL;
              adv_cnt = 7'h0;
            end else begin
              adv_cnt = cnt_q + 7'h1;
            end
          end
          TX_CDEL: begin
            adv_state = TX_ASLOT;
          end
          TX_ASLOT: begin
            next_acked = ~link.bus;
            adv_state = TX_ADEL;
          end
          TX_ADEL: begin
            adv_state = TX_EOF;
            adv_cnt = 7'h0;
          end
          TX_EOF: begin
            if (cnt_q == 7'(`CDRF_EOF_LEN - 1)) begin
              adv_state = TX_IDLE;
              next_done = 1'b1;
            end else begin
              adv_cnt = cnt_q + 7'h1;
            end
          end
          default: begin
            adv_state = TX_IDLE;
          end
        endcase
        case (adv_state)
          TX_SOF: fbit = `CDRF_DOMINANT;
          TX_ARB: fbit = arb_q[5'd31 - adv_cnt[4:0]];
          TX_CTRL: fbit = ctrl_q[3'd5 - adv_cnt[2:0]];
          TX_DATA: fbit = data_q[6'd63 - adv_cnt[5:0]];
          TX_CRC: fbit = crc_q[4'd14 - adv_cnt[3:0]];
          default: fbit = `CDRF_RECESSIVE;
        endcase
      end
    end
    if (go) begin
      next_state = adv_state;
      next_cnt = adv_cnt;
      next_level = fbit;
      next_stuff = 1'b0;
      if (adv_state == TX_IDLE) begin
        next_last = `CDRF_RECESSIVE;
        next_run = 3'h0;
      end else if (fbit == last_q) begin
        next_run = run_q + 3'h1;
      end else begin
        next_last = fbit;
        next_run = 3'h1;
      end
      if (adv_state == TX_SOF) begin
        next_crc = cdrf_crc_step(15'h0, fbit);
      end else if (adv_state == TX_ARB || adv_state == TX_CTRL || adv_state == TX_DATA) begin
        next_crc = cdrf_crc_step(crc_q, fbit);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div_q <= 16'h0;
      state_q <= TX_IDLE;
      cnt_q <= 7'h0;
      arb_last_q <= 7'h0;
      nbits_q <= 7'h0;
      arb_q <= 32'h0;
      ctrl_q <= 6'h0;
      data_q <= 64'h0;
      crc_q <= 15'h0;
      run_q <= 3'h0;
      last_q <= 1'b1;
      stuff_q <= 1'b0;
      level_q <= 1'b1;
      pend_q <= 1'b0;
      refused_q <= 1'b0;
      done_q <= 1'b0;
      acked_q <= 1'b0;
      lost_q <= 1'b0;
    end else begin
      div_q <= next_div;
      state_q <= next_state;
      cnt_q <= next_cnt;
      arb_last_q <= next_arb_last;
      nbits_q <= next_nbits;
      arb_q <= next_arb;
      ctrl_q <= next_ctrl;
      data_q <= next_data;
      crc_q <= next_crc;
      run_q <= next_run;
      last_q <= next_last;
      stuff_q <= next_stuff;
      level_q <= next_level;
      pend_q <= next_pend;
      refused_q <= next_refused;
      done_q <= next_done;
      acked_q <= next_acked;
      lost_q <= next_lost;
    end
  end

  assign link.bit_tick = tick;
  assign link.tx_level = level_q;
  assign busy = pend_q || (state_q != TX_IDLE);
  assign refused = refused_q;
  assign done = done_q;
  assign acked = acked_q;
  assign lost = lost_q;
endmodule
`default_nettype wire

// [rtl/cdrf_rx.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cdrf_map.svh"
module cdrf_rx
  import cdrf_pkg::*;
(
  input wire logic clk,            // System clock
  input wire logic reset_n,        // Synchronous reset, active low
  cdrf_if.rx_end link,             // Shared bus
  input wire logic ack_en,         // Node neither bus-off nor asleep
  output logic rx_valid,           // Good frame pulse
  output logic rx_ext,             // Extended format
  output logic rx_rtr,             // Remote frame
  output logic [28:0] rx_id,       // Identifier, base in [28:18]
  output logic [3:0] rx_dlc,       // Data length code
  output logic [63:0] rx_data,     // First byte in [63:56]
  output logic crc_err,            // CRC mismatch pulse
  output logic stuff_err,          // Stuffing error pulse
  output logic form_err            // Fixed-form bit error pulse
);
  cdrf_rx_state_t state_q, next_state;
  cdrf_cnt_t cnt_q, next_cnt, nbits_q, next_nbits;
  logic [37:0] hdr_q, next_hdr, nh;
  logic [63:0] sr_q, next_sr, data_q, next_data;
  logic [14:0] crc_q, next_crc, rcrc_q, next_rcrc;
  logic [28:0] id_q, next_id;
  logic [3:0] dlc_q, next_dlc;
  logic [2:0] run_q, next_run;
  logic ext_q, next_ext, rtr_q, next_rtr, last_q, next_last, ack_q, next_ack;
  logic valid_q, next_valid, cerr_q, next_cerr, serr_q, next_serr, ferr_q, next_ferr;
  logic b, region, fin;

  assign b = link.bus;
  assign region = (state_q == RX_HDR) || (state_q == RX_DATA) || (state_q == RX_CRC) ||
                  (state_q == RX_CDEL);

  always_comb begin
    next_state = state_q;
    next_cnt = cnt_q;
    next_nbits = nbits_q;
    next_hdr = hdr_q;
    next_sr = sr_q;
    next_data = data_q;
    next_crc = crc_q;
    next_rcrc = rcrc_q;
    next_id = id_q;
    next_dlc = dlc_q;
    next_run = run_q;
    next_ext = ext_q;
    next_rtr = rtr_q;
    next_last = last_q;
    next_ack = ack_q;
    next_valid = 1'b0;
    next_cerr = 1'b0;
    next_serr = 1'b0;
    next_ferr = 1'b0;
    nh = {hdr_q[36:0], b};
    fin = 1'b0;
    if (link.bit_tick) begin
      if (region && run_q == 3'(`CDRF_STUFF_RUN)) begin
        if (b == last_q) begin
          next_serr = 1'b1;
          next_state = RX_WAIT;
          next_cnt = 7'h0;
        end else begin
          next_last = b;
          next_run = 3'h1;
        end
      end else begin
        if (region) begin
          next_run = (b == last_q) ? run_q + 3'h1 : 3'h1;
          next_last = b;
        end
        case (state_q)
          RX_IDLE: begin
            if (b == `CDRF_DOMINANT) begin
              next_state = RX_HDR;
              next_cnt = 7'h0;
              next_crc = cdrf_crc_step(15'h0, b);
              next_last = b;
              next_run = 3'h1;
            end
          end
          RX_HDR: begin
            next_hdr = nh;
            next_crc = cdrf_crc_step(crc_q, b);
            next_cnt = cnt_q + 7'h1;
            if (cnt_q == 7'(`CDRF_IDE_POS)) begin
              next_ext = b;
            end
            if (!ext_q && cnt_q == 7'(`CDRF_STD_HDR_LAST)) begin
              next_id = {nh[17:7], 18'h0};
              fin = 1'b1;
            end
            if (ext_q && cnt_q == 7'(`CDRF_EXT_HDR_LAST)) begin
              next_id = {nh[37:27], nh[24:7]};
              fin = 1'b1;
            end
            if (fin) begin
              next_rtr = nh[6];
              next_dlc = nh[3:0];
              next_cnt = 7'h0;
              next_sr = 64'h0;
              if (nh[6]) begin
                next_nbits = 7'h0;
              end else if (nh[3]) begin
                next_nbits = 7'h40;
              end else begin
                next_nbits = {1'b0, nh[2:0], 3'h0};
              end
              next_state = (nh[6] || nh[3:0] == 4'h0) ? RX_CRC : RX_DATA;
            end
          end
          RX_DATA: begin
            next_sr = {sr_q[62:0], b};
            next_crc = cdrf_crc_step(crc_q, b);
            next_cnt = cnt_q + 7'h1;
            if (cnt_q == nbits_q - 7'h1) begin
              next_state = RX_CRC;
              next_cnt = 7'h0;
            end
          end
          RX_CRC: begin
            next_rcrc = {rcrc_q[13:0], b};
            next_cnt = cnt_q + 7'h1;
            if (cnt_q == 7'(`CDRF_CRC_LEN - 1)) begin
              next_state = RX_CDEL;
            end
          end
          RX_CDEL: begin
            if (b != `CDRF_RECESSIVE) begin
              next_ferr = 1'b1;
              next_state = RX_WAIT;
              next_cnt = 7'h0;
            end else if (rcrc_q != crc_q) begin
              next_cerr = 1'b1;
              next_state = RX_WAIT;
              next_cnt = 7'h0;
            end else begin
              next_state = RX_ASLOT;
              next_ack = ack_en ? `CDRF_DOMINANT : `CDRF_RECESSIVE;
            end
          end
          RX_ASLOT: begin
            next_ack = `CDRF_RECESSIVE;
            next_state = RX_ADEL;
          end
          RX_ADEL, RX_EOF: begin
            next_cnt = (state_q == RX_ADEL) ? 7'h0 : cnt_q + 7'h1;
            next_state = (state_q == RX_ADEL) ? RX_EOF : state_q;
            if (b != `CDRF_RECESSIVE) begin
              next_ferr = 1'b1;
              next_state = RX_WAIT;
              next_cnt = 7'h0;
            end else if (state_q == RX_EOF && cnt_q == 7'(`CDRF_EOF_LEN - 1)) begin
              next_state = RX_IDLE;
              next_valid = 1'b1;
              next_data = sr_q << (7'h40 - nbits_q);
            end
          end
          RX_WAIT: begin
            next_cnt = b ? cnt_q + 7'h1 : 7'h0;
            if (b && cnt_q == 7'(`CDRF_EOF_LEN - 1)) begin
              next_state = RX_IDLE;
            end
          end
          default: begin
            next_state = RX_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= RX_IDLE;
      cnt_q <= 7'h0;
      nbits_q <= 7'h0;
      hdr_q <= 38'h0;
      sr_q <= 64'h0;
      data_q <= 64'h0;
      crc_q <= 15'h0;
      rcrc_q <= 15'h0;
      id_q <= 29'h0;
      dlc_q <= 4'h0;
      run_q <= 3'h0;
      ext_q <= 1'b0;
      rtr_q <= 1'b0;
      last_q <= 1'b1;
      ack_q <= 1'b1;
      valid_q <= 1'b0;
      cerr_q <= 1'b0;
      serr_q <= 1'b0;
      ferr_q <= 1'b0;
    end else begin
      state_q <= next_state;
      cnt_q <= next_cnt;
      nbits_q <= next_nbits;
      hdr_q <= next_hdr;
      sr_q <= next_sr;
      data_q <= next_data;
      crc_q <= next_crc;
      rcrc_q <= next_rcrc;
      id_q <= next_id;
      dlc_q <= next_dlc;
      run_q <= next_run;
      ext_q <= next_ext;
      rtr_q <= next_rtr;
      last_q <= next_last;
      ack_q <= next_ack;
      valid_q <= next_valid;
      cerr_q <= next_cerr;
      serr_q <= next_serr;
      ferr_q <= next_ferr;
    end
  end

  assign link.ack_level = ack_q;
  assign rx_valid = valid_q;
  assign rx_ext = ext_q;
  assign rx_rtr = rtr_q;
  assign rx_id = id_q;
  assign rx_dlc = dlc_q;
  assign rx_data = data_q;
  assign crc_err = cerr_q;
  assign stuff_err = serr_q;
  assign form_err = ferr_q;
endmodule
`default_nettype wire

// [verif/cdrf_chk.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cdrf_map.svh"
module cdrf_chk #(
  parameter int BIT_DIV = `CDRF_BIT_DIV
) (
  input wire logic clk,       // Clock
  input wire logic reset_n,   // Reset
  input wire logic bit_tick,  // Bit end
  input wire logic tx_level,  // Tx drive
  input wire logic ack_level, // Rx drive
  input wire logic bus        // Bus level
);
  logic [15:0] gap, next_gap;
  logic [3:0] tail, next_tail, run, next_run;
  logic seen, next_seen, ack_q;

  // Tail counts the eight recessive bits that follow an ack slot
  always_comb begin
    next_gap = bit_tick ? 16'h0 : gap + 16'h1;
    next_seen = seen | bit_tick;
    next_tail = (bit_tick && tail != 4'h0) ? tail - 4'h1 : tail;
    if (ack_level && !ack_q) begin
      next_tail = 4'h8;
    end
    next_run = run;
    if (bit_tick) begin
      next_run = bus ? 4'h0 : run + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gap <= 16'h0;
      tail <= 4'h0;
      run <= 4'h0;
      seen <= 1'b0;
      ack_q <= 1'b1;
    end else begin
      gap <= next_gap;
      tail <= next_tail;
      run <= next_run;
      seen <= next_seen;
      ack_q <= ack_level;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  chk_tick_spacing: assert property (bit_tick && seen |-> gap == 16'(BIT_DIV - 1))
    else $error("bit strobe spacing wrong");
  chk_tx_on_tick: assert property ($changed(tx_level) |-> $past(bit_tick))
    else $error("tx level moved mid bit");
  chk_ack_on_tick: assert property ($changed(ack_level) |-> $past(bit_tick))
    else $error("ack level moved mid bit");
  chk_ack_tx_recessive: assert property (!ack_level |-> tx_level)
    else $error("transmitter dominant in ack slot");
  chk_ack_one_bit: assert property (!ack_level && bit_tick |=> ack_level)
    else $error("ack held past one bit");
  chk_ack_after_delim: assert property ($fell(ack_level) |-> $past(bus))
    else $error("ack without recessive delimiter");
  chk_tail_recessive: assert property (tail != 4'h0 |-> bus)
    else $error("dominant bit in frame tail");
  chk_stuff_run: assert property (run < 4'h6)
    else $error("six dominant bits in a row");

  cov_ack: cover property ($fell(ack_level));
  cov_stuff: cover property (bit_tick && run == 4'h5 && bus);
  cov_tail_end: cover property (bit_tick && tail == 4'h1);
endmodule
`default_nettype wire

// [verif/test_can_data_remote_framer.sv]
`timescale 1ns/100ps
`default_nettype none
module test_can_data_remote_framer
  import cdrf_pkg::*;
;
  localparam int DIV = 4;
  localparam logic [14:0] POLY = 15'h4599;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic req, req_ext, req_rtr, ack_en, rec, busy, refused, done, acked, lost;
  logic rx_valid, rx_ext, rx_rtr, crc_err, stuff_err, form_err, valid2, crc2, stuff2, form2;
  logic [28:0] req_id, rx_id;
  logic [3:0] req_dlc, rx_dlc;
  logic [63:0] req_data, rx_data;
  logic raw[$], q[$], got[$];
  int nb, vcnt = 0, v2cnt = 0, c2cnt = 0, ecnt = 0, sidx = 0, s2cnt = 0, f2cnt = 0;
  int bad_count = 0;
  int num_checks = 0;

  cdrf_if link();
  cdrf_if bad_link();
  // Only one transmitter drives the link, so every identifier has a single owner
  cdrf_tx #(.BIT_DIV(DIV)) u_cdrf_tx (.clk(clk), .reset_n(reset_n), .link(link), .req(req),
    .req_ext(req_ext), .req_rtr(req_rtr), .req_id(req_id), .req_dlc(req_dlc), .req_data(req_data),
    .busy(busy), .refused(refused), .done(done), .acked(acked), .lost(lost));
  cdrf_rx u_cdrf_rx (.clk(clk), .reset_n(reset_n), .link(link), .ack_en(ack_en), .rx_valid(rx_valid),
    .rx_ext(rx_ext), .rx_rtr(rx_rtr), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data),
    .crc_err(crc_err), .stuff_err(stuff_err), .form_err(form_err));
  // Second receiver sits on a line the bench drives, so frames can be broken on purpose
  cdrf_rx u_cdrf_rx_bad (.clk(clk), .reset_n(reset_n), .link(bad_link), .ack_en(1'b1),
    .rx_valid(valid2), .rx_ext(), .rx_rtr(), .rx_id(), .rx_dlc(), .rx_data(), .crc_err(crc2),
    .stuff_err(stuff2), .form_err(form2));
  cdrf_chk #(.BIT_DIV(DIV)) u_cdrf_chk (.clk(clk), .reset_n(reset_n), .bit_tick(link.bit_tick),
    .tx_level(link.tx_level), .ack_level(link.ack_level), .bus(link.bus));

  task automatic cmp(input logic [63:0] got_v, input logic [63:0] exp_v);
    num_checks++;
    if (got_v !== exp_v) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic put(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      raw.push_back(v[i]);
    end
  endtask

  // Expected wire bits of one frame, stuffing and tail included
  task automatic build(input logic ext, rtr, input logic [28:0] id, input logic [3:0] dlc,
      input logic [63:0] data, input logic [1:0] rsv, input logic [14:0] flip, input logic ack);
    logic [14:0] crc;
    logic last;
    int run;
    crc = 15'h0;
    raw.delete();
    nb = rtr ? 0 : (dlc[3] ? 8 : int'(dlc[2:0]));
    put(64'h0, 1);
    put(64'(id[28:18]), 11);
    if (ext) begin
      put(64'h3, 2);
      put(64'(id[17:0]), 18);
      put({61'h0, rtr, rsv}, 3);
    end else begin
      put({61'h0, rtr, 1'b0, rsv[0]}, 3);
    end
    put(64'(dlc), 4);
    put(data >> (64 - 8 * nb), 8 * nb);
    foreach (raw[i]) begin
      crc = {crc[13:0], 1'b0} ^ ((crc[14] ^ raw[i]) ? POLY : 15'h0);
    end
    put(64'(crc ^ flip), 15);
    q.delete();
    sidx = 0;
    last = 1'b1;
    run = 0;
    foreach (raw[i]) begin
      q.push_back(raw[i]);
      run = (raw[i] == last) ? run + 1 : 1;
      last = raw[i];
      if (run == 5) begin
        if (sidx == 0) begin
          sidx = q.size();
        end
        q.push_back(!last);
        last = !last;
        run = 1;
      end
    end
    for (int i = 0; i < 10; i++) begin
      q.push_back(i == 1 ? ack : 1'b1);
    end
  endtask

  task automatic send(input logic ext, rtr, input logic [28:0] id, input logic [3:0] dlc,
      input logic [63:0] data);
    int n, v0;
    build(ext, rtr, id, dlc, data, 2'b00, 15'h0, !ack_en);
    got.delete();
    v0 = vcnt;
    rec = 1'b1;
    req = 1'b1;
    {req_ext, req_rtr, req_id, req_dlc, req_data} = {ext, rtr, id, dlc, data};
    @(negedge clk);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    rec = 1'b0;
    cmp(64'(got.size()), 64'(q.size()));
    foreach (q[i]) begin
      cmp(64'(got[i]), 64'(q[i]));
    end
    cmp(64'({vcnt - v0 == 1, rx_ext, rx_rtr, rx_dlc, acked}), 64'({1'b1, ext, rtr, dlc, ack_en}));
    cmp(64'(rx_id), 64'(ext ? id : {id[28:18], 18'h0}));
    cmp(rx_data, data & ~({64{1'b1}} >> (8 * nb)));
  endtask

  // Brk 1 inverts the first stuff bit, brk 2 drives the CRC delimiter dominant
  task automatic inject(input logic [14:0] flip, input int brk);
    logic ackd, hit;
    int v0, c0, s0, f0, at;
    build(1'b1, 1'b0, 29'h0abc_1234, 4'h2, 64'ha5c3_0000_0000_0000, 2'b11, flip, 1'b1);
    at = (brk == 1) ? sidx : ((brk == 2) ? q.size() - 10 : -1);
    hit = (flip != 0) || (brk != 0);
    v0 = v2cnt;
    c0 = c2cnt;
    s0 = s2cnt;
    f0 = f2cnt;
    ackd = 1'b1;
    foreach (q[i]) begin
      bad_link.bit_tick = 1'b0;
      bad_link.tx_level = (i == at) ? !q[i] : q[i];
      repeat (2) @(negedge clk);
      if (i == q.size() - 9) ackd = bad_link.bus;
      bad_link.bit_tick = 1'b1;
      @(negedge clk);
    end
    bad_link.bit_tick = 1'b0;
    @(negedge clk);
    cmp(64'({v2cnt - v0 == 1, c2cnt - c0 == 1, ackd}), 64'({!hit, flip != 0, hit}));
    cmp(64'({s2cnt - s0 == 1, f2cnt - f0 == 1}), 64'({brk == 1, brk == 2}));
  endtask

  // Sampled on the falling edge, where strobe and bus have settled
  always @(negedge clk) begin
    if (rec && link.bit_tick === 1'b1 && (got.size() > 0 || link.bus === 1'b0)) begin
      got.push_back(link.bus);
    end
    if (reset_n === 1'b1) begin
      vcnt <= vcnt + int'(rx_valid === 1'b1);
      v2cnt <= v2cnt + int'(valid2 === 1'b1);
      c2cnt <= c2cnt + int'(crc2 === 1'b1);
      s2cnt <= s2cnt + int'(stuff2 === 1'b1);
      f2cnt <= f2cnt + int'(form2 === 1'b1);
      ecnt <= ecnt + int'({crc_err, stuff_err, form_err, lost} !== 4'h0);
    end
  end

  initial begin
    forever #4 clk = ~clk;
  end

  initial begin
    {req, req_ext, req_rtr, rec, req_id, req_dlc, req_data} = '0;
    ack_en = 1'b1;
    bad_link.bit_tick = 1'b0;
    bad_link.tx_level = 1'b1;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    for (int i = 0; i < 16; i++) begin
      send(i[0], 1'b0, {i[3:0], 25'h00f_00ff}, i[3:0], 64'h0000_00ff_ff00_0f1e);
    end
    send(1'b0, 1'b1, 29'h1fbf_ffff, 4'h3, 64'h1234_5678_9abc_def0);
    send(1'b1, 1'b1, 29'h0aaa_5555, 4'h8, 64'hffff_ffff_ffff_ffff);
    ack_en = 1'b0;
    send(1'b0, 1'b0, 29'h0400_0000, 4'h1, 64'h8000_0000_0000_0000);
    ack_en = 1'b1;
    req = 1'b1;
    req_id = 29'h1fc0_0000;
    @(negedge clk);
    req = 1'b0;
    cmp(64'({refused, busy}), 64'h2);
    repeat (3 * DIV) @(negedge clk);
    cmp(64'({busy, link.tx_level}), 64'h1);
    req = 1'b1;
    req_id = 29'h0;
    @(negedge clk);
    req = 1'b0;
    repeat (20 * DIV) @(negedge clk);
    reset_n = 1'b0;
    repeat (4) @(negedge clk);
    cmp(64'({busy, link.tx_level, link.ack_level}), 64'h3);
    reset_n = 1'b1;
    @(negedge clk);
    send(1'b1, 1'b0, 29'h0000_0001, 4'h7, 64'h0102_0304_0506_0708);
    inject(15'h0, 0);
    inject(15'h0040, 0);
    inject(15'h0, 1);
    inject(15'h0, 2);
    cmp(64'(ecnt), 64'h0);
    summarize();
  end

  // Roughly four times the expected length of the run
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
